// file: hw/sdw_fifo.sv
// synchronous fifo with a registered read stage
module sdw_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             srst_i,
	// fill side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// drain side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = AW + 1;
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
	localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_ptr_q, wr_ptr_d;
	logic [AW-1:0]    rd_ptr_q, rd_ptr_d;
	logic [CW-1:0]    cnt_q, cnt_d;
	logic [WIDTH-1:0] out_q, out_d;
	logic             out_vld_q, out_vld_d;
	logic             wr;
	logic             load;

	// full only when every storage word holds data
	assign in_ready_o  = (cnt_q != FULL_CNT);
	assign out_valid_o = out_vld_q;
	assign out_data_o  = out_q;

	// pointer, level and read stage next values
	always_comb begin
		wr        = in_valid_i && in_ready_o;
		load      = (cnt_q != '0) && (!out_vld_q || out_ready_i);
		wr_ptr_d  = wr_ptr_q;
		rd_ptr_d  = rd_ptr_q;
		out_d     = out_q;
		out_vld_d = out_vld_q;
		cnt_d     = cnt_q;
		if (wr) begin
			wr_ptr_d = (wr_ptr_q == LAST_PTR) ? '0 : wr_ptr_q + 1'b1;
		end
		if (load) begin
			rd_ptr_d  = (rd_ptr_q == LAST_PTR) ? '0 : rd_ptr_q + 1'b1;
			out_d     = mem_q[rd_ptr_q];
			out_vld_d = 1'b1;
		end else if (out_ready_i) begin
			out_vld_d = 1'b0;
		end
		if (wr && !load) begin
			cnt_d = cnt_q + 1'b1;
		end else if (load && !wr) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	// storage has no reset; the pointers, level and read stage take one
	always_ff @(posedge clk_i) begin
		if (wr) begin
			mem_q[wr_ptr_q] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			wr_ptr_q  <= '0;
			rd_ptr_q  <= '0;
			cnt_q     <= '0;
			out_q     <= '0;
			out_vld_q <= 1'b0;
		end else begin
			wr_ptr_q  <= wr_ptr_d;
			rd_ptr_q  <= rd_ptr_d;
			cnt_q     <= cnt_d;
			out_q     <= out_d;
			out_vld_q <= out_vld_d;
		end
	end

endmodule

// file: hw/sdw_sync.sv
// two-stage level synchroniser into the domain of clk_i
module sdw_sync (
	// clock
	input  wire logic clk_i,
	// asynchronous level in
	input  wire logic d_i,
	// synchronised level out
	output logic      q_o
);

	logic meta_q;
	logic sync_q;

	// first stage feeds only the second
	always_ff @(posedge clk_i) begin
		meta_q <= d_i;
		sync_q <= meta_q;
	end

	assign q_o = sync_q;

endmodule

// file: hw/sdw_top.sv
module sdw_top #(
	parameter int FIFO_DEPTH = sdw_pkg::FIFO_DEPTH
) (
	// core clock and reset
	input  wire logic                       mclk_i,
	input  wire logic                       srst_i,
	// serial write link
	input  wire logic                       sclk_i,
	input  wire logic                       frame_n_i,
	input  wire logic                       din_i,
	// converter pacing
	input  wire logic                       load_ready_i,
	// converter register and status
	output logic      [sdw_pkg::CODE_W-1:0] dac_code_o,
	output logic      [sdw_pkg::WORD_W-1:0] word_o,
	output logic                            code_upd_o,
	output logic                            written_o,
	output logic                            abort_o,
	output logic                            lost_o,
	output logic                            frame_busy_o
);

	// ---- link domain, clocked by the falling serial clock ----

	sdw_pkg::sdw_link_e                lnk_state_q, lnk_state_d;
	logic [sdw_pkg::BITCNT_W-1:0]      bit_cnt_q, bit_cnt_d;
	logic [sdw_pkg::WORD_W-1:0]        shift_q, shift_d;
	logic [sdw_pkg::WORD_W-1:0]        lword_q, lword_d;
	logic                              ltog_q, ltog_d;
	logic                              lrst_s;
	logic                              shift_en;
	logic                              frame_end;

	// core reset brought into the link domain as a level
	sdw_sync u_lrst_sync (
		.clk_i (sclk_i),
		.d_i   (srst_i),
		.q_o   (lrst_s)
	);

	// a bit is taken only while armed and framed
	assign shift_en = (lnk_state_q == sdw_pkg::LNK_ARMED) && !frame_n_i && !lrst_s;

	// frame state and bit count next values
	always_comb begin
		lnk_state_d = lnk_state_q;
		bit_cnt_d   = bit_cnt_q;
		frame_end   = 1'b0;
		case (lnk_state_q)
			sdw_pkg::LNK_ARMED: begin
				if (shift_en) begin
					bit_cnt_d = bit_cnt_q + 1'b1;
					if (bit_cnt_q == sdw_pkg::LAST_BIT) begin
						frame_end   = 1'b1;
						lnk_state_d = sdw_pkg::LNK_DONE;
					end
				end
			end
			sdw_pkg::LNK_DONE: begin
				// edges after a full word are ignored
				lnk_state_d = sdw_pkg::LNK_DONE;
			end
			default: begin
				lnk_state_d = sdw_pkg::LNK_DONE;
			end
		endcase
	end

	// frame select high re-arms at once, even with the clock stopped;
	// a partial count is thrown away here
	always_ff @(negedge sclk_i or posedge frame_n_i) begin
		if (frame_n_i) begin
			lnk_state_q <= sdw_pkg::LNK_ARMED;
			bit_cnt_q   <= sdw_pkg::BITCNT_RST;
		end else if (lrst_s) begin
			lnk_state_q <= sdw_pkg::LNK_DONE;
			bit_cnt_q   <= sdw_pkg::BITCNT_RST;
		end else begin
			lnk_state_q <= lnk_state_d;
			bit_cnt_q   <= bit_cnt_d;
		end
	end

	// shift register, completed word and completion toggle
	always_comb begin
		shift_d = shift_q;
		lword_d = lword_q;
		ltog_d  = ltog_q;
		if (shift_en) begin
			shift_d = {shift_q[sdw_pkg::WORD_W-2:0], din_i};
		end
		if (frame_end) begin
			lword_d = {shift_q[sdw_pkg::WORD_W-2:0], din_i};
			ltog_d  = !ltog_q;
		end
	end

	// word held stable until the next full frame, at least 16 bits later
	always_ff @(negedge sclk_i) begin
		if (lrst_s) begin
			shift_q <= sdw_pkg::WORD_RST;
			lword_q <= sdw_pkg::WORD_RST;
			ltog_q  <= 1'b0;
		end else begin
			shift_q <= shift_d;
			lword_q <= lword_d;
			ltog_q  <= ltog_d;
		end
	end

	// ---- core domain ----

	logic                              tog_s;
	logic                              frm_s;
	logic                              tog_prev_q, tog_prev_d;
	logic                              frm_prev_q, frm_prev_d;
	logic                              tog_edge;
	logic                              frm_rise;
	logic                              frm_fall;

	// completion toggle and frame level cross as levels
	sdw_sync u_tog_sync (
		.clk_i (mclk_i),
		.d_i   (ltog_q),
		.q_o   (tog_s)
	);

	sdw_sync u_frm_sync (
		.clk_i (mclk_i),
		.d_i   (frame_n_i),
		.q_o   (frm_s)
	);

	assign tog_edge = tog_s ^ tog_prev_q;
	assign frm_rise = frm_s && !frm_prev_q;
	assign frm_fall = !frm_s && frm_prev_q;

	always_comb begin
		tog_prev_d = tog_s;
		frm_prev_d = frm_s;
	end

	// reset takes the current toggle level so no false word appears
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			tog_prev_q <= tog_s;
			frm_prev_q <= 1'b1;
		end else begin
			tog_prev_q <= tog_prev_d;
			frm_prev_q <= frm_prev_d;
		end
	end

	// pending word waits here while the fifo is full
	logic                              pend_q, pend_d;
	logic [sdw_pkg::WORD_W-1:0]        pend_word_q, pend_word_d;
	logic                              seen_q, seen_d;
	logic                              abort_q, abort_d;
	logic                              lost_q, lost_d;
	logic                              busy_q, busy_d;
	logic                              fifo_in_ready;
	logic                              push;

	assign push = pend_q && fifo_in_ready;

	// capture, back-pressure and frame status next values
	always_comb begin
		pend_d      = pend_q;
		pend_word_d = pend_word_q;
		seen_d      = seen_q;
		lost_d      = 1'b0;
		abort_d     = 1'b0;
		busy_d      = !frm_s;
		if (push) begin
			pend_d = 1'b0;
		end
		if (tog_edge) begin
			// lword_q is stable for many core cycles around the toggle
			pend_word_d = lword_q;
			pend_d      = 1'b1;
			lost_d      = pend_q && !push;
		end
		if (frm_fall) begin
			seen_d = 1'b0;
		end
		// a completion in the same cycle wins over the frame clear
		if (tog_edge) begin
			seen_d = 1'b1;
		end
		// frame closed with no completed word: nothing reaches the output
		if (frm_rise && !seen_q && !tog_edge) begin
			abort_d = 1'b1;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			pend_q      <= 1'b0;
			pend_word_q <= sdw_pkg::WORD_RST;
			seen_q      <= 1'b0;
			abort_q     <= 1'b0;
			lost_q      <= 1'b0;
			busy_q      <= 1'b0;
		end else begin
			pend_q      <= pend_d;
			pend_word_q <= pend_word_d;
			seen_q      <= seen_d;
			abort_q     <= abort_d;
			lost_q      <= lost_d;
			busy_q      <= busy_d;
		end
	end

	// words queue so a slow converter does not drop back-to-back frames
	logic                              fifo_out_valid;
	logic [sdw_pkg::WORD_W-1:0]        fifo_out_data;
	logic                              pop;

	sdw_fifo #(
		.WIDTH (sdw_pkg::WORD_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_i       (mclk_i),
		.srst_i      (srst_i),
		.in_valid_i  (pend_q),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (pend_word_q),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (load_ready_i),
		.out_data_o  (fifo_out_data)
	);

	assign pop = fifo_out_valid && load_ready_i;

	// converter register
	logic [sdw_pkg::CODE_W-1:0]        code_q, code_d;
	logic [sdw_pkg::WORD_W-1:0]        word_q, word_d;
	logic                              upd_q, upd_d;
	logic                              written_q, written_d;

	always_comb begin
		code_d    = code_q;
		word_d    = word_q;
		upd_d     = 1'b0;
		written_d = written_q;
		if (pop) begin
			code_d    = fifo_out_data[sdw_pkg::CODE_W-1:0];
			word_d    = fifo_out_data;
			upd_d     = 1'b1;
			written_d = 1'b1;
		end
	end

	// zero code from reset until a full frame arrives
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			code_q    <= sdw_pkg::ZERO_CODE;
			word_q    <= sdw_pkg::WORD_RST;
			upd_q     <= 1'b0;
			written_q <= 1'b0;
		end else begin
			code_q    <= code_d;
			word_q    <= word_d;
			upd_q     <= upd_d;
			written_q <= written_d;
		end
	end

	// outputs, all from flip-flops
	assign dac_code_o   = code_q;
	assign word_o       = word_q;
	assign code_upd_o   = upd_q;
	assign written_o    = written_q;
	assign abort_o      = abort_q;
	assign lost_o       = lost_q;
	assign frame_busy_o = busy_q;

endmodule

// file: pkg/sdw_pkg.sv
package sdw_pkg;

	// frame and code geometry
	localparam int FRAME_BITS = 16;
	localparam int WORD_W     = 16;
	localparam int CODE_W     = 12;
	localparam int BITCNT_W   = 5;
	localparam logic [BITCNT_W-1:0] LAST_BIT = 5'h0f;
	localparam logic [BITCNT_W-1:0] BITCNT_RST = 5'h00;

	// reset values
	localparam logic [CODE_W-1:0] ZERO_CODE = 12'h000;
	localparam logic [WORD_W-1:0] WORD_RST  = 16'h0000;

	// buffering between the link and the converter register
	localparam int FIFO_DEPTH = 16;

	// link timing limits kept by the host
	localparam int SCLK_MAX_MHZ   = 20;
	localparam int SCLK_MIN_NS    = 1000 / SCLK_MAX_MHZ;
	localparam int MCLK_MHZ       = 100;
	localparam int MCLK_PERIOD_NS = 1000 / MCLK_MHZ;
	// whole core cycles in the shortest link bit, rounded down
	localparam int SCLK_MIN_CYC   = SCLK_MIN_NS / MCLK_PERIOD_NS;

	// link-side frame state
	typedef enum logic [1:0] {
		LNK_ARMED = 2'b00,
		LNK_DONE  = 2'b01
	} sdw_link_e;

endpackage

// file: tb/sdw_chk_asserts.sv
// watches the top ports only; all checks run on the core clock
module sdw_chk #(
	parameter int FIFO_DEPTH = 16
) (
	// core side
	input wire logic        mclk_i,
	input wire logic        srst_i,
	input wire logic        load_ready_i,
	// link side
	input wire logic        sclk_i,
	input wire logic        frame_n_i,
	input wire logic        din_i,
	// observed outputs
	input wire logic [11:0] dac_code_o,
	input wire logic [15:0] word_o,
	input wire logic        code_upd_o,
	input wire logic        written_o,
	input wire logic        abort_o,
	input wire logic        lost_o,
	input wire logic        frame_busy_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking dc @(posedge mclk_i); endclocking
	default disable iff (srst_i);

	// word and code outputs may only move in the cycle the update pulse stands
	AST_CODE_HOLD: assert property (!code_upd_o |-> $stable({word_o, dac_code_o}))
		else $error("code moved without update");
	AST_CODE_IS_WORD: assert property (dac_code_o == word_o[11:0])
		else $error("code not low bits of word");
	// zero output until the first full frame lands
	AST_ZERO_FIRST: assert property (!written_o && !code_upd_o |-> dac_code_o == 12'h000)
		else $error("nonzero code before first write");
	AST_WRITTEN_STAYS: assert property (written_o |=> written_o)
		else $error("written flag dropped");
	// abort only after frame select has gone high
	AST_ABORT_RISE: assert property (abort_o |-> $past(frame_n_i, 2))
		else $error("abort without frame rise");
	AST_ABORT_PULSE: assert property (abort_o |=> !abort_o)
		else $error("abort longer than one cycle");
	AST_BUSY_RISE: assert property ($rose(frame_busy_o) |-> !$past(frame_n_i, 2))
		else $error("busy without frame select");
	// converter takes a word only when paced in
	AST_UPD_READY: assert property (code_upd_o |-> $past(load_ready_i))
		else $error("update while converter stalled");
endmodule

bind sdw_top sdw_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_sdw_chk (
	.mclk_i(mclk_i), .srst_i(srst_i), .load_ready_i(load_ready_i),
	.sclk_i(sclk_i), .frame_n_i(frame_n_i), .din_i(din_i),
	.dac_code_o(dac_code_o), .word_o(word_o), .code_upd_o(code_upd_o),
	.written_o(written_o), .abort_o(abort_o), .lost_o(lost_o),
	.frame_busy_o(frame_busy_o)
);

// file: tb/sdw_host.sv
// host side of the serial write link; clock idles high between frames
module sdw_host (
	// serial write link
	output logic sclk_o,
	output logic frame_n_o,
	output logic din_o
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HALF_NS = 40; // 12.5 MHz, under the host limit

	initial begin
		sclk_o = 1'b1;
		frame_n_o = 1'b1;
		din_o = 1'b0;
	end

	// clocks with no frame, only needed around reset
	task automatic idle(input int n);
		#3;
		repeat (n) begin
			#HALF_NS sclk_o = 1'b0;
			#HALF_NS sclk_o = 1'b1;
		end
	endtask

	// msb first; fewer than 16 edges aborts, more overruns
	task automatic send(input logic [31:0] data, input int nbits);
		#3 frame_n_o = 1'b0;
		for (int i = nbits - 1; i >= 0; i--) begin
			din_o = data[i];
			#HALF_NS sclk_o = 1'b0;
			#HALF_NS sclk_o = 1'b1;
		end
		din_o = ~din_o; // released line shows no stale bit
		frame_n_o = 1'b1;
		#(4 * HALF_NS);
	endtask
endmodule

// file: tb/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	// stimulus and observed outputs
	logic        mclk_i = 1'b0;
	logic        srst_i = 1'b1;
	logic        load_ready_i = 1'b1;
	logic        sclk, frame_n, din;
	logic [11:0] dac_code;
	logic [15:0] word;
	logic        upd, written, abort_p, lost, busy;
	int          error_cnt = 0;
	int          checked = 0;
	int          upd_cnt = 0;
	int          abort_cnt = 0;
	int          lost_cnt = 0;

	always #5 mclk_i = ~mclk_i;

	sdw_host u_sdw_host (.sclk_o(sclk), .frame_n_o(frame_n), .din_o(din));

	sdw_top u_sdw_top (
		.mclk_i(mclk_i), .srst_i(srst_i), .sclk_i(sclk), .frame_n_i(frame_n),
		.din_i(din), .load_ready_i(load_ready_i), .dac_code_o(dac_code),
		.word_o(word), .code_upd_o(upd), .written_o(written), .abort_o(abort_p),
		.lost_o(lost), .frame_busy_o(busy)
	);

	// pulses last one core cycle, so count them every edge
	always @(posedge mclk_i) begin
		if (upd === 1'b1) upd_cnt <= upd_cnt + 1;
		if (abort_p === 1'b1) abort_cnt <= abort_cnt + 1;
		if (lost === 1'b1) lost_cnt <= lost_cnt + 1;
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s exp %h seen %h", what, exp, seen);
		end
	endtask

	// bounded wait for the update count to reach n
	task automatic wait_upd(input int n);
		int k;
		k = 0;
		while (upd_cnt < n && k < 200) begin
			@(posedge mclk_i);
			k++;
		end
		if (upd_cnt < n) begin
			check("updates", 16'(upd_cnt), 16'(n));
			report_and_stop();
		end
	endtask

	task automatic t_write(input logic [15:0] w);
		int n;
		n = upd_cnt + 1;
		u_sdw_host.send({16'h0000, w}, 16);
		wait_upd(n);
		check("word", word, w);
		check("code", {4'h0, dac_code}, {4'h0, w[11:0]});
		check("written", {15'h0, written}, 16'h0001);
	endtask

	// short frame must leave the output alone
	task automatic t_abort(input int nbits, input logic [15:0] prev);
		int a, n;
		a = abort_cnt;
		n = upd_cnt;
		u_sdw_host.send(32'h0000_5a5a, nbits);
		repeat (10) @(posedge mclk_i);
		check("aborts", 16'(abort_cnt - a), 16'h0001);
		check("no update", 16'(upd_cnt - n), 16'h0000);
		check("word kept", word, prev);
		check("idle busy", {15'h0, busy}, 16'h0000);
	endtask

	// edges past the sixteenth are ignored
	task automatic t_overrun();
		int n;
		n = upd_cnt + 1;
		u_sdw_host.send(32'h000a_bcde, 20);
		wait_upd(n);
		repeat (20) @(posedge mclk_i);
		check("overrun word", word, 16'habcd);
		check("one update", 16'(upd_cnt - n), 16'h0000);
	endtask

	// converter stalled: 18 words queue, the 19th replaces the pending one
	task automatic t_stall();
		int n, l;
		@(posedge mclk_i) load_ready_i <= 1'b0;
		n = upd_cnt;
		l = lost_cnt;
		for (int i = 0; i < 19; i++) u_sdw_host.send({16'h0000, 16'ha000 + 16'(i)}, 16);
		check("stalled", 16'(upd_cnt - n), 16'h0000);
		check("lost", 16'(lost_cnt - l), 16'h0001);
		@(posedge mclk_i) load_ready_i <= 1'b1;
		wait_upd(n + 18);
		repeat (20) @(posedge mclk_i);
		check("drained", 16'(upd_cnt - n), 16'h0012);
		check("last word", word, 16'ha012);
	endtask

	initial begin
		u_sdw_host.idle(4); // reset spans four link clocks
		@(posedge mclk_i) srst_i <= 1'b0;
		u_sdw_host.idle(4);
		t_abort(7, 16'h0000);
		check("not written", {15'h0, written}, 16'h0000);
		t_write(16'h8421);
		t_abort(15, 16'h8421);
		t_abort(1, 16'h8421);
		t_overrun();
		t_write(16'h7ffe);
		t_stall();
		report_and_stop();
	end
endmodule
